// File: hw/rds_sequencer.sv
// Recovery and descent flight-state sequencer, states 7 to 11
// Notes on behaviour
// - Descending below main altitude fires main fuse
// - Rising descent rate fires main while check enabled
// - Failure check disabled five seconds after drogue
// - Main firing stamps time, moves to state 8
// - Filtered-pressure landing stamps time, enters state 9
// - Landed: beeping on, log ten seconds, state 10
// - Stop logging, write summaries, then state 11
// - Beep once per second forever in state 11
// - Flush log to card every 200 ms
// - Fire regardless of fuse detection, stamp issue time
// - Estimates update every 10 ms cycle
module rds_sequencer
  import rds_pkg::*;
#(
  parameter int unsigned CYCLE_LEN = CYCLE_CLKS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic drogue_deployed,
  input wire logic [rds_pkg::ALT_W-1:0] main_alt,
  input wire logic [rds_pkg::ALT_W-1:0] altitude,
  input wire logic descending,
  input wire logic descent_rate_rising,
  input wire logic landing_detected,
  input wire logic fuse_present,
  input wire logic summary_done,
  output logic main_fuse_fire,
  output logic stamp_valid,
  output logic [1:0] stamp_kind,
  output logic [rds_pkg::TIME_W-1:0] stamp_time,
  output logic estimate_update,
  output logic logging_active,
  output logic log_flush,
  output logic summary_write,
  output logic buzzer,
  output logic [3:0] flight_state
);
  import rds_pkg::*;

  if (CYCLE_LEN < 2) begin
    $error("rds_sequencer CYCLE_LEN must be at least 2");
  end

  // ------------------------------------------------------------
  // Measurement cycle and time base
  // ------------------------------------------------------------
  logic cycle_tick;
  rds_tick_counter #(
    .LENGTH(CYCLE_LEN)
  ) u_cycle (
    .clock(clock),
    .rst_n(rst_n),
    .restart(1'b0),
    .tick(cycle_tick)
  );
  assign estimate_update = cycle_tick;

  logic [TIME_W-1:0] time_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      time_reg <= '0;
    end else if (cycle_tick) begin
      time_reg <= time_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // State machine
  // ------------------------------------------------------------
  rds_state_e state_reg;
  rds_state_e state_next;
  logic [9:0] timer_reg;
  logic fail_check_reg;
  logic main_fired_reg;
  logic fire_cond;

  // Fuse presence is deliberately ignored: a false negative must not block firing
  assign fire_cond = !main_fired_reg && descending &&
    ((altitude < main_alt) || (fail_check_reg && descent_rate_rising));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RDS_IDLE: if (drogue_deployed) state_next = RDS_DROGUE;
      RDS_DROGUE: if (fire_cond) state_next = RDS_AWAIT_LAND;
      RDS_AWAIT_LAND: if (landing_detected) state_next = RDS_LANDED;
      RDS_LANDED: begin
        if (cycle_tick && timer_reg == 10'(POST_LAND_TICKS - 1)) begin
          state_next = RDS_STOP_REC;
        end
      end
      RDS_STOP_REC: if (summary_done) state_next = RDS_BEEP;
      RDS_BEEP: state_next = RDS_BEEP;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RDS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // One timer serves the failure window, the post-landing window and the beep period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg <= '0;
    end else if (state_next != state_reg) begin
      timer_reg <= '0;
    end else if (cycle_tick) begin
      if (state_reg == RDS_BEEP && timer_reg == 10'(BEEP_PERIOD_TICKS - 1)) begin
        timer_reg <= '0;
      end else if (timer_reg != 10'h3ff) begin
        timer_reg <= timer_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fail_check_reg <= 1'b0;
    end else if (state_reg == RDS_IDLE && drogue_deployed) begin
      fail_check_reg <= 1'b1;
    end else if (state_next != RDS_DROGUE ||
                 (cycle_tick && timer_reg == 10'(FAIL_TICKS - 1))) begin
      fail_check_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_fired_reg <= 1'b0;
      main_fuse_fire <= 1'b0;
    end else begin
      main_fuse_fire <= (state_reg == RDS_DROGUE) && fire_cond;
      if (state_reg == RDS_DROGUE && fire_cond) main_fired_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Timestamps
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stamp_valid <= 1'b0;
      stamp_kind <= 2'h0;
      stamp_time <= '0;
    end else begin
      stamp_valid <= 1'b0;
      if (state_reg == RDS_DROGUE && fire_cond) begin
        stamp_valid <= 1'b1;
        stamp_kind <= STAMP_MAIN;
        stamp_time <= time_reg;
      end else if (state_reg == RDS_AWAIT_LAND && landing_detected) begin
        stamp_valid <= 1'b1;
        stamp_kind <= STAMP_LAND;
        stamp_time <= time_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Logging, flush and summary
  // ------------------------------------------------------------
  logic [4:0] flush_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      logging_active <= 1'b0;
      flush_reg <= '0;
      log_flush <= 1'b0;
      summary_write <= 1'b0;
    end else begin
      logging_active <= (state_next == RDS_DROGUE) || (state_next == RDS_AWAIT_LAND) ||
        (state_next == RDS_LANDED);
      log_flush <= 1'b0;
      if (!logging_active) begin
        flush_reg <= '0;
      end else if (cycle_tick) begin
        if (flush_reg == 5'(FLUSH_TICKS - 1)) begin
          flush_reg <= '0;
          log_flush <= 1'b1;
        end else begin
          flush_reg <= flush_reg + 1'b1;
        end
      end
      summary_write <= (state_next == RDS_STOP_REC);
    end
  end

  // ------------------------------------------------------------
  // Buzzer and state code
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buzzer <= 1'b0;
    end else if (state_reg == RDS_BEEP) begin
      buzzer <= timer_reg < 10'(BEEP_ON_TICKS);
    end else if (state_reg == RDS_LANDED) begin
      buzzer <= timer_reg[5];
    end else begin
      buzzer <= 1'b0;
    end
  end

  always_comb begin
    unique case (state_reg)
      RDS_AWAIT_LAND: flight_state = STATE_CODE_AWAIT_LAND;
      RDS_LANDED: flight_state = STATE_CODE_LANDED;
      RDS_STOP_REC: flight_state = STATE_CODE_STOP_REC;
      RDS_BEEP: flight_state = STATE_CODE_BEEP;
      default: flight_state = STATE_CODE_DROGUE;
    endcase
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_fire;
    main_fuse_fire;
  endsequence

  // Remembers any earlier pulse so a second one is caught however late it comes
  logic fired_seen_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fired_seen_reg <= 1'b0;
    end else if (main_fuse_fire) begin
      fired_seen_reg <= 1'b1;
    end
  end

  a_fire_once: assert property (@(posedge clock) disable iff (!rst_n)
    s_fire |-> !fired_seen_reg) else $error("main fuse fired twice");
  a_fire_stamps: assert property (@(posedge clock) disable iff (!rst_n)
    s_fire |-> stamp_valid && stamp_kind == STAMP_MAIN) else $error("main stamp missing");
  a_fire_state: assert property (@(posedge clock) disable iff (!rst_n)
    s_fire |-> flight_state == STATE_CODE_AWAIT_LAND) else $error("state not 8 after fire");
  a_state_forward: assert property (@(posedge clock) disable iff (!rst_n)
    flight_state >= $past(flight_state)) else $error("state code went back");
  a_beep_stays: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == RDS_BEEP |=> state_reg == RDS_BEEP) else $error("left beep state");
  a_no_log_late: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == RDS_BEEP |-> !logging_active) else $error("logging after stop");
  a_flush_logging: assert property (@(posedge clock) disable iff (!rst_n)
    log_flush |-> $past(logging_active)) else $error("flush while not logging");
  a_check_window: assert property (@(posedge clock) disable iff (!rst_n)
    fail_check_reg |-> state_reg == RDS_DROGUE && timer_reg < 10'(FAIL_TICKS))
    else $error("failure check beyond window");
  a_land_stamp: assert property (@(posedge clock) disable iff (!rst_n)
    state_reg == RDS_AWAIT_LAND && landing_detected |=> stamp_valid && stamp_kind == STAMP_LAND)
    else $error("landing stamp missing");
endmodule

// File: common/rds_pkg.sv
// Constants and types for the recovery descent sequencer
package rds_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYCLE_MS = 10;
  localparam int unsigned FLUSH_MS = 200;
  localparam int unsigned FAIL_WINDOW_MS = 5000;
  localparam int unsigned POST_LAND_MS = 10000;
  localparam int unsigned BEEP_PERIOD_MS = 1000;
  localparam int unsigned BEEP_ON_MS = 100;
  localparam int unsigned CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;
  localparam int unsigned FLUSH_TICKS = FLUSH_MS / CYCLE_MS;
  localparam int unsigned FAIL_TICKS = FAIL_WINDOW_MS / CYCLE_MS;
  localparam int unsigned POST_LAND_TICKS = POST_LAND_MS / CYCLE_MS;
  localparam int unsigned BEEP_PERIOD_TICKS = BEEP_PERIOD_MS / CYCLE_MS;
  localparam int unsigned BEEP_ON_TICKS = BEEP_ON_MS / CYCLE_MS;
  // ------------------------------------------------------------
  // Data
  // ------------------------------------------------------------
  localparam int unsigned ALT_W = 16;
  localparam int unsigned TIME_W = 32;
  localparam logic [ALT_W-1:0] MAIN_ALT_DEFAULT = 16'h00c8;
  localparam logic [3:0] STATE_CODE_DROGUE = 4'h7;
  localparam logic [3:0] STATE_CODE_AWAIT_LAND = 4'h8;
  localparam logic [3:0] STATE_CODE_LANDED = 4'h9;
  localparam logic [3:0] STATE_CODE_STOP_REC = 4'ha;
  localparam logic [3:0] STATE_CODE_BEEP = 4'hb;
  localparam logic [1:0] STAMP_MAIN = 2'h1;
  localparam logic [1:0] STAMP_LAND = 2'h2;
  typedef enum logic [5:0] {
    RDS_IDLE = 6'b000001,
    RDS_DROGUE = 6'b000010,
    RDS_AWAIT_LAND = 6'b000100,
    RDS_LANDED = 6'b001000,
    RDS_STOP_REC = 6'b010000,
    RDS_BEEP = 6'b100000
  } rds_state_e;
endpackage

// File: hw/rds_tick_counter.sv
// Free-running divider producing a one-cycle tick every LENGTH clocks
module rds_tick_counter #(
  parameter int unsigned LENGTH = 500000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic restart,
  output logic tick
);
  localparam int unsigned CW = (LENGTH > 1) ? $clog2(LENGTH) : 1;
  localparam logic [CW-1:0] LAST = CW'(LENGTH - 1);
  logic [CW-1:0] count_reg;

  if (LENGTH < 2) begin
    $error("rds_tick_counter LENGTH must be at least 2");
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (restart || count_reg == LAST) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign tick = (count_reg == LAST) && !restart;
endmodule

// File: tb/rds_card_model.sv
// Behavioural card and fuse side of the recovery descent sequencer
module rds_card_model #(
  parameter int unsigned WRITE_CLKS = 40
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic summary_write,
  input wire logic main_fuse_fire,
  output logic summary_done,
  output logic [7:0] fires
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Card write
  // ------------------------------------------------------------
  int unsigned busy_reg;
  // Slow card: the write is acknowledged only after WRITE_CLKS clocks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 0;
      summary_done <= 1'b0;
    end else begin
      summary_done <= summary_write && (busy_reg == WRITE_CLKS - 1);
      busy_reg <= summary_write ? busy_reg + 1 : 0;
    end
  end
  // ------------------------------------------------------------
  // Fuse driver
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fires <= 8'h00;
    end else if (main_fuse_fire) begin
      fires <= fires + 8'h01;
    end
  end
endmodule

// File: tb/test_rds_sequencer.sv
// Self-checking testbench for the recovery descent sequencer
module test_rds_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import rds_pkg::*;
  // Short cycle keeps the ten second landed phase affordable
  localparam int CL = 10;
  logic clock, rst_n, drogue_deployed, descending, descent_rate_rising, landing_detected;
  logic fuse_present, summary_done, main_fuse_fire, stamp_valid, estimate_update;
  logic logging_active, log_flush, summary_write, buzzer;
  logic [ALT_W-1:0] main_alt, altitude;
  logic [1:0] stamp_kind;
  logic [TIME_W-1:0] stamp_time, main_time;
  logic [3:0] flight_state;
  logic [7:0] fires;
  int num_errors = 0;
  int total_checks = 0;
  int clk_cnt = 0;
  rds_sequencer #(.CYCLE_LEN(CL)) dut_u (.clock(clock), .rst_n(rst_n),
    .drogue_deployed(drogue_deployed), .main_alt(main_alt), .altitude(altitude),
    .descending(descending), .descent_rate_rising(descent_rate_rising),
    .landing_detected(landing_detected), .fuse_present(fuse_present),
    .summary_done(summary_done), .main_fuse_fire(main_fuse_fire),
    .stamp_valid(stamp_valid), .stamp_kind(stamp_kind), .stamp_time(stamp_time),
    .estimate_update(estimate_update), .logging_active(logging_active),
    .log_flush(log_flush), .summary_write(summary_write), .buzzer(buzzer),
    .flight_state(flight_state));
  rds_card_model card_u (.clock(clock), .rst_n(rst_n), .summary_write(summary_write),
    .main_fuse_fire(main_fuse_fire), .summary_done(summary_done), .fires(fires));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) clk_cnt <= clk_cnt + 1;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_hi(ref logic s, input int lim, output int n);
    // Step off the edge so a freshly launched output is not read in a race
    #1;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    descending <= 1'b0;
    descent_rate_rising <= 1'b0;
    landing_detected <= 1'b0;
    altitude <= 16'h03e8;
    cyc(10);
    check("state in reset", flight_state, STATE_CODE_DROGUE);
    check("fire in reset", {main_fuse_fire, logging_active, buzzer, summary_write}, 0);
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    drogue_deployed <= 1'b1;
    @(posedge clock);
    drogue_deployed <= 1'b0;
    cyc(3);
    check("logging on", logging_active, 1);
  endtask
  task automatic run_window();
    int n;
    do_reset();
    cyc((FAIL_TICKS + 10) * CL);
    @(posedge clock);
    descending <= 1'b1;
    descent_rate_rising <= 1'b1;
    altitude <= MAIN_ALT_DEFAULT;
    cyc(50);
    check("late failure fire", fires, 0);
    check("fire at threshold", fires, 0);
    @(posedge clock);
    altitude <= MAIN_ALT_DEFAULT - 16'h0001;
    wait_hi(main_fuse_fire, 5, n);
    check("fire below altitude", main_fuse_fire, 1);
  endtask
  task automatic run_failure();
    int n;
    do_reset();
    cyc(30);
    check("no early fire", fires, 0);
    @(posedge clock);
    descending <= 1'b1;
    fuse_present <= 1'b1;
    descent_rate_rising <= 1'b1;
    wait_hi(main_fuse_fire, 5, n);
    check("failure fire", main_fuse_fire, 1);
    check("main stamp", {stamp_valid, stamp_kind}, {1'b1, STAMP_MAIN});
    check("state after fire", flight_state, STATE_CODE_AWAIT_LAND);
    main_time = stamp_time;
    @(posedge clock);
    altitude <= 16'h0010;
    wait_hi(estimate_update, 2 * CL, n);
    cyc(1);
    wait_hi(estimate_update, 2 * CL, n);
    check("update spacing", n + 1, CL);
    wait_hi(log_flush, 300, n);
    cyc(1);
    wait_hi(log_flush, 300, n);
    check("flush spacing", n + 1, FLUSH_TICKS * CL);
    check("single fire", fires, 1);
  endtask
  task automatic run_landing();
    int n;
    int t0;
    int hi;
    int fl;
    int st;
    @(posedge clock);
    landing_detected <= 1'b1;
    wait_hi(stamp_valid, 5, n);
    t0 = clk_cnt;
    check("land kind", stamp_kind, STAMP_LAND);
    check("land later", stamp_time > main_time, 1);
    check("state landed", flight_state, STATE_CODE_LANDED);
    @(posedge clock);
    landing_detected <= 1'b0;
    wait_hi(buzzer, 40 * CL, n);
    check("landed beep", buzzer, 1);
    check("landed logging", logging_active, 1);
    n = 0;
    while (flight_state === STATE_CODE_LANDED && n < 12000) begin
      cyc(1);
      n++;
    end
    // First tick after entry may come anywhere within one cycle, so round up
    check("landed time", (clk_cnt - t0 + CL - 1) / CL, POST_LAND_TICKS);
    check("state stop", flight_state, STATE_CODE_STOP_REC);
    check("summary write", summary_write, 1);
    n = 0;
    while (flight_state === STATE_CODE_STOP_REC && n < 100) begin
      cyc(1);
      n++;
    end
    check("state final", flight_state, STATE_CODE_BEEP);
    check("logging off", logging_active, 0);
    hi = 0;
    fl = 0;
    st = 0;
    repeat (3 * BEEP_PERIOD_TICKS * CL) begin
      cyc(1);
      hi += (buzzer === 1'b1);
      fl += (log_flush !== 1'b0);
      st += (flight_state !== STATE_CODE_BEEP);
    end
    check("beep on time", hi, 3 * BEEP_ON_TICKS * CL);
    check("no flush after stop", fl, 0);
    check("stays final", st, 0);
  endtask
  // ------------------------------------------------------------
  // Sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    drogue_deployed = 1'b0;
    main_alt = MAIN_ALT_DEFAULT;
    altitude = 16'h03e8;
    descending = 1'b0;
    descent_rate_rising = 1'b0;
    landing_detected = 1'b0;
    fuse_present = 1'b0;
    run_window();
    run_failure();
    run_landing();
    end_of_test();
  end
  // Whole run is about 19000 clocks; more than twice that means a hang
  initial begin
    repeat (45000) @(posedge clock);
    num_errors++;
    end_of_test();
  end
endmodule
